/* File: rtl/adcsq_pkg.sv */
package adcsq_pkg;
    // Control word fields
    localparam int unsigned CW_WRITE     = 15;
    localparam int unsigned CW_REPEAT    = 14;
    localparam int unsigned CW_SEL_HI    = 13;
    localparam int unsigned CW_TSENSE    = 5;
    localparam int unsigned CW_EXTREF    = 2;
    localparam int unsigned CW_AVG       = 1;
    localparam int unsigned CW_STANDBY   = 0;
    localparam logic [14:0] CW_RESET     = 15'h0000;

    // Frame layout
    localparam logic [4:0]  FRAME_LAST   = 5'h0F;
    localparam logic [15:0] ALL_ONES     = 16'hFFFF;
    localparam logic [3:0]  TEMP_INDEX   = 4'h8;
    localparam logic [3:0]  TAG_TEMP     = 4'h8;
    localparam logic [3:0]  TAG_TEMP_AVG = 4'h9;

    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 5;
    localparam int unsigned TEMP_CONV_MAX_NS = 100000;
    localparam int unsigned TEMP_CONV_CYCLES = TEMP_CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned PD_MIN_NS        = 90;
    localparam int unsigned PD_CYCLES        = (PD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_MAX_NS       = 60;
    localparam int unsigned RST_CYCLES       = RST_MAX_NS / CLK_PERIOD_NS;

    // Result buffer
    localparam int unsigned FIFO_WIDTH = 16;
    localparam int unsigned FIFO_DEPTH = 4;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SHIFT = 4'h2,
        ST_HOLD  = 4'h4,
        ST_SKIP  = 4'h8
    } adcsq_frame_t;
endpackage : adcsq_pkg

/* File: rtl/adcsq_fifo.sv */
`timescale 1ns/10ps
module adcsq_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk_sys_in,    // System clock
    input  wire logic             rstn_in,       // Sync reset, active low
    input  wire logic             flush_in,      // Drop all entries
    input  wire logic             wr_valid_in,   // Write request
    output logic                  wr_ready_out,  // Room available
    input  wire logic [WIDTH-1:0] wr_data_in,    // Write word
    output logic                  rd_valid_out,  // Head word present
    input  wire logic             rd_ready_in,   // Pop head
    output logic      [WIDTH-1:0] rd_data_out    // Head word
);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic [CW-1:0]    slot;
    logic             push;
    logic             pop;

    assign push         = wr_valid_in & wr_ready_out;
    assign pop          = rd_ready_in & rd_valid_out;
    assign rd_valid_out = (count_q != '0);
    assign rd_data_out  = mem_q[0];
    assign slot         = count_q - CW'(pop);

    always_comb begin
        count_d = count_q + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || flush_in) begin
            count_q      <= '0;
            wr_ready_out <= 1'b1;
        end else begin
            count_q      <= count_d;
            wr_ready_out <= (count_d < DEPTH_C);
        end
    end

    // Head always sits in slot 0 so read data comes from a register
    always_ff @(posedge clk_sys_in) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!rstn_in) begin
                mem_q[i] <= '0;
            end else if (push && CW'(i) == slot) begin
                mem_q[i] <= wr_data_in;
            end else if (pop && i < DEPTH - 1) begin
                mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
            end
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    a_fifo_no_overrun: assert property (count_q == DEPTH_C |-> !push)
        else $error("fifo written while full");
endmodule : adcsq_fifo

/* File: rtl/adcsq_top.sv */
`timescale 1ns/10ps
module adcsq_top #(
    parameter int unsigned TEMP_CONV_CYCLES = adcsq_pkg::TEMP_CONV_CYCLES
) (
    input  wire logic        clk_sys_in,                  // System clock, 200 MHz
    input  wire logic        rstn_in,                     // Sync reset, active low
    input  wire logic        cs_n_in,                     // Frame select pin, active low
    input  wire logic        sclk_in,                     // Serial clock pin
    input  wire logic        din_in,                      // Serial data in pin
    input  wire logic        powerdown_reset_n_in,        // Power-down/reset pin, active low
    input  wire logic [11:0] result_bits_in,              // Converter result
    input  wire logic        result_valid_in,             // Converter result valid
    output logic             result_ready_out,            // Result buffer has room
    output logic             dout_out,                    // Serial data out
    output logic             dout_oe_n_out,               // Data out enable, low drives
    output logic             temp_conversion_busy_out,    // Temperature conversion running
    output logic             conv_start_out,              // Start conversion pulse
    output logic [3:0]       conv_channel_out,            // Channel tag being converted
    output logic             conv_abort_out,              // Abort conversion pulse
    output logic             reference_source_select_out, // 1 = external reference
    output logic             temp_average_enable_out,     // Temperature averaging on
    output logic             standby_out,                 // Standby mode
    output logic             powered_down_out             // Power-down mode
);
    localparam logic [14:0] TEMP_LAST = 15'(TEMP_CONV_CYCLES - 1);
    localparam logic [4:0]  PD_LIMIT  = 5'(adcsq_pkg::PD_CYCLES);

    logic [3:0]             sync1_q;
    logic [3:0]             sync2_q;
    logic                   cs_prev_q;
    logic                   sclk_prev_q;
    logic                   cs_s;
    logic                   sclk_s;
    logic                   din_s;
    logic                   pd_low;
    logic                   cs_fall;
    logic                   cs_rise;
    logic                   sclk_fall;
    logic [4:0]             pd_cnt_q;
    adcsq_pkg::adcsq_frame_t st_q;
    logic [4:0]             bit_cnt_q;
    logic [14:0]            in_sh_q;
    logic [15:0]            word_in;
    logic [14:0]            word_low;
    logic [15:0]            out_sh_q;
    logic [15:0]            out_word;
    logic [14:0]            ctrl_q;
    logic [8:0]             pend_q;
    logic [8:0]             rest;
    logic [8:0]             sel_now;
    logic [3:0]             idx;
    logic                   busy_q;
    logic                   grace_q;
    logic [14:0]            temp_cnt_q;
    logic                   standby_q;
    logic                   sb_apply_q;
    logic                   frame_start;
    logic                   skip_frame;
    logic                   shift_edge;
    logic                   last_edge;
    logic                   wr_ok;
    logic                   issue;
    logic                   temp_issue;
    logic                   temp_done;
    logic                   abort;
    logic                   avg_eff;
    logic                   ref_bit;
    logic                   fifo_rd_valid;
    logic                   fifo_pop;
    logic [15:0]            fifo_rd_data;

    // Channel k of inputs 0..7 sits at bit 13-k; temperature is index 8
    function automatic logic [8:0] sel_of(input logic [14:0] cw);
        logic [8:0] m;
        m = '0;
        for (int k = 0; k < 8; k++) begin
            m[k] = cw[adcsq_pkg::CW_SEL_HI - k];
        end
        m[8] = cw[adcsq_pkg::CW_TSENSE];
        return m;
    endfunction : sel_of

    function automatic logic [3:0] first_set(input logic [8:0] m);
        logic [3:0] r;
        r = '0;
        for (int k = 8; k >= 0; k--) begin
            if (m[k]) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction : first_set

    // Pin synchronisers; only second stage is used
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            sync1_q     <= 4'hD;
            sync2_q     <= 4'hD;
            cs_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q     <= {powerdown_reset_n_in, din_in, sclk_in, cs_n_in};
            sync2_q     <= sync1_q;
            cs_prev_q   <= sync2_q[0];
            sclk_prev_q <= sync2_q[1];
        end
    end

    assign cs_s      = sync2_q[0];
    assign sclk_s    = sync2_q[1];
    assign din_s     = sync2_q[2];
    assign pd_low    = !sync2_q[3];
    assign cs_fall   = cs_prev_q & !cs_s;
    assign cs_rise   = !cs_prev_q & cs_s;
    assign sclk_fall = sclk_prev_q & !sclk_s;

    assign skip_frame  = busy_q & !grace_q;
    assign frame_start = (st_q == adcsq_pkg::ST_IDLE) & cs_fall & !pd_low;
    assign shift_edge  = (st_q == adcsq_pkg::ST_SHIFT) & sclk_fall & !cs_s & !cs_rise;
    assign last_edge   = shift_edge & (bit_cnt_q == adcsq_pkg::FRAME_LAST);
    assign word_in     = {in_sh_q, din_s};
    assign word_low    = word_in[14:0];
    assign wr_ok       = last_edge & word_in[adcsq_pkg::CW_WRITE];
    assign abort       = wr_ok & grace_q & busy_q & word_in[adcsq_pkg::CW_STANDBY];
    assign sel_now     = sel_of(ctrl_q);
    assign idx         = first_set(pend_q);
    assign issue       = frame_start & !skip_frame & !standby_q & (pend_q != '0);
    assign temp_issue  = issue & (idx == adcsq_pkg::TEMP_INDEX);
    assign temp_done   = result_valid_in & result_ready_out & conv_channel_out[3];
    assign avg_eff     = ctrl_q[adcsq_pkg::CW_AVG] & ctrl_q[adcsq_pkg::CW_TSENSE];
    assign ref_bit     = ctrl_q[adcsq_pkg::CW_EXTREF];
    assign fifo_pop    = frame_start & !skip_frame & !standby_q & fifo_rd_valid;

    always_comb begin
        rest = pend_q;
        rest[idx] = 1'b0;
        if (rest == '0 && ctrl_q[adcsq_pkg::CW_REPEAT]) begin
            rest = sel_now;
        end
    end

    always_comb begin
        if (skip_frame || standby_q || !fifo_rd_valid) begin
            out_word = adcsq_pkg::ALL_ONES;
        end else begin
            out_word = fifo_rd_data;
        end
    end

    // Pin low time decides reset versus power-down
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pd_cnt_q         <= '0;
            powered_down_out <= 1'b0;
        end else if (pd_low) begin
            pd_cnt_q         <= (pd_cnt_q == PD_LIMIT) ? pd_cnt_q : pd_cnt_q + 5'h01;
            powered_down_out <= (pd_cnt_q >= PD_LIMIT - 5'h01);
        end else begin
            pd_cnt_q         <= '0;
            powered_down_out <= 1'b0;
        end
    end

    // Frame tracking
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            st_q <= adcsq_pkg::ST_IDLE;
        end else begin
            unique case (st_q)
                adcsq_pkg::ST_IDLE: begin
                    if (frame_start) begin
                        st_q <= skip_frame ? adcsq_pkg::ST_SKIP : adcsq_pkg::ST_SHIFT;
                    end
                end
                adcsq_pkg::ST_SHIFT: begin
                    if (cs_rise) begin
                        st_q <= adcsq_pkg::ST_IDLE;
                    end else if (last_edge) begin
                        st_q <= adcsq_pkg::ST_HOLD;
                    end
                end
                adcsq_pkg::ST_HOLD,
                adcsq_pkg::ST_SKIP: begin
                    if (cs_rise) begin
                        st_q <= adcsq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= adcsq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            bit_cnt_q <= '0;
            in_sh_q   <= '0;
        end else if (frame_start) begin
            bit_cnt_q <= '0;
        end else if (shift_edge) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            in_sh_q   <= word_low;
        end
    end

    // Serial output
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            dout_oe_n_out <= 1'b1;
            dout_out      <= 1'b1;
            out_sh_q      <= adcsq_pkg::ALL_ONES;
        end else if (frame_start) begin
            dout_oe_n_out <= 1'b0;
            dout_out      <= out_word[15];
            out_sh_q      <= {out_word[14:0], 1'b1};
        end else if (cs_rise || last_edge) begin
            dout_oe_n_out <= 1'b1;
        end else if (shift_edge) begin
            dout_out      <= out_sh_q[15];
            out_sh_q      <= {out_sh_q[14:0], 1'b1};
        end
    end

    // Control word
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            ctrl_q <= adcsq_pkg::CW_RESET;
        end else if (wr_ok) begin
            ctrl_q <= word_low;
        end else if (cs_rise && sb_apply_q && ctrl_q[adcsq_pkg::CW_STANDBY]) begin
            ctrl_q[adcsq_pkg::CW_AVG] <= 1'b0;
        end
    end

    // Standby entry and exit at frame end, or at once on abort
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            standby_q  <= 1'b0;
            sb_apply_q <= 1'b0;
        end else if (abort) begin
            standby_q  <= 1'b1;
            sb_apply_q <= 1'b1;
        end else if (wr_ok) begin
            sb_apply_q <= 1'b1;
        end else if (cs_rise) begin
            sb_apply_q <= 1'b0;
            if (sb_apply_q) begin
                standby_q <= ctrl_q[adcsq_pkg::CW_STANDBY];
            end
        end
    end

    // Channel sequencer
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            pend_q <= '0;
        end else if (wr_ok) begin
            pend_q <= sel_of(word_low);
        end else if (issue) begin
            pend_q <= rest;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            conv_start_out   <= 1'b0;
            conv_channel_out <= '0;
            conv_abort_out   <= 1'b0;
        end else begin
            conv_start_out <= issue;
            conv_abort_out <= (cs_rise && st_q == adcsq_pkg::ST_SHIFT) || abort;
            if (issue) begin
                if (idx == adcsq_pkg::TEMP_INDEX) begin
                    conv_channel_out <= avg_eff ? adcsq_pkg::TAG_TEMP_AVG : adcsq_pkg::TAG_TEMP;
                end else begin
                    conv_channel_out <= idx;
                end
            end
        end
    end

    // Temperature conversion timing
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || pd_low) begin
            busy_q     <= 1'b0;
            grace_q    <= 1'b0;
            temp_cnt_q <= '0;
        end else begin
            if (temp_issue) begin
                grace_q <= 1'b1;
            end else if (cs_rise) begin
                grace_q <= 1'b0;
            end
            if (temp_issue) begin
                busy_q     <= 1'b1;
                temp_cnt_q <= '0;
            end else if (abort || (busy_q && (temp_done || temp_cnt_q == TEMP_LAST))) begin
                busy_q     <= 1'b0;
            end else if (busy_q) begin
                temp_cnt_q <= temp_cnt_q + 15'h0001;
            end
        end
    end

    assign temp_conversion_busy_out = busy_q;

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            reference_source_select_out <= 1'b0;
            temp_average_enable_out     <= 1'b0;
        end else begin
            reference_source_select_out <= ref_bit;
            temp_average_enable_out     <= avg_eff;
        end
    end

    assign standby_out = standby_q;

    adcsq_fifo #(
        .WIDTH (adcsq_pkg::FIFO_WIDTH),
        .DEPTH (adcsq_pkg::FIFO_DEPTH)
    ) u_result_fifo (
        .clk_sys_in   (clk_sys_in),
        .rstn_in      (rstn_in),
        .flush_in     (pd_low),
        .wr_valid_in  (result_valid_in),
        .wr_ready_out (result_ready_out),
        .wr_data_in   ({conv_channel_out, result_bits_in}),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (fifo_pop),
        .rd_data_out  (fifo_rd_data)
    );

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    sequence s_frame_open;
        frame_start && !skip_frame;
    endsequence

    sequence s_short_end;
        cs_rise && st_q == adcsq_pkg::ST_SHIFT;
    endsequence

    a_frame_drive_on: assert property (s_frame_open |=> !dout_oe_n_out)
        else $error("data out not enabled at frame start");
    a_frame_release: assert property (last_edge |=> dout_oe_n_out)
        else $error("data out not released after 16th edge");
    a_temp_busy_rise: assert property (temp_issue |=> temp_conversion_busy_out ##1 grace_q)
        else $error("busy did not rise on temp conversion");
    a_temp_busy_bound: assert property (temp_conversion_busy_out && temp_cnt_q == TEMP_LAST && !temp_issue
                                        |=> !temp_conversion_busy_out)
        else $error("temp conversion exceeded its time");
    a_skip_frame_ones: assert property (st_q == adcsq_pkg::ST_SKIP |-> dout_out && $stable(ctrl_q))
        else $error("ignored frame changed state or data");
    a_standby_ones: assert property (frame_start && standby_q |=> dout_out)
        else $error("standby read not all ones");
    a_short_frame: assert property (s_short_end |=> dout_oe_n_out && $stable(ctrl_q) && conv_abort_out)
        else $error("short frame not terminated");
    a_write_apply: assert property (wr_ok |=> ctrl_q == $past(word_low))
        else $error("valid write not applied");
    a_pin_reset: assert property (pd_low |=> ctrl_q == adcsq_pkg::CW_RESET && !standby_out)
        else $error("pin low did not reset control");
    a_pin_powerdown: assert property (pd_low && pd_cnt_q >= PD_LIMIT |=> powered_down_out)
        else $error("long pin low did not power down");
    a_seq_stop: assert property (issue && rest == '0 |=> pend_q == '0)
        else $error("one-shot sequence did not stop");
    a_repeat_wrap: assert property (issue && pend_q == (9'h001 << idx) && ctrl_q[adcsq_pkg::CW_REPEAT]
                                    |=> pend_q == $past(sel_now))
        else $error("repeat did not wrap to first channel");
    a_abort_standby: assert property (abort |=> standby_out && !temp_conversion_busy_out)
        else $error("temp abort did not enter standby");
    a_ref_follow: assert property (ref_bit |=> reference_source_select_out)
        else $error("reference select not following control");
endmodule : adcsq_top

/* File: verif/adcsq_host.sv */
`timescale 1ns/10ps
module adcsq_host (
    input  wire logic clk_sys_in,   // System clock
    input  wire logic dout_in,      // Device data out
    input  wire logic dout_oe_n_in, // Device data out enable, low drives
    output logic      cs_n_out,     // Frame select
    output logic      sclk_out,     // Serial clock, still between frames
    output logic      din_out       // Device data in
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out  = 1'b0;
    end
    // Frame of n bits, 160 ns serial clock
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'hFFFF;
        @(negedge clk_sys_in) cs_n_out = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            repeat (16) @(negedge clk_sys_in);
            din_out  = w[i];
            sclk_out = 1'b1;
            repeat (16) @(negedge clk_sys_in);
            r[i]     = dout_oe_n_in ? ~dout_in : dout_in;
            sclk_out = 1'b0;
        end
        repeat (16) @(negedge clk_sys_in);
        cs_n_out = 1'b1;
        din_out  = ~din_out;
        repeat (40) @(negedge clk_sys_in);
    endtask : xfer
endmodule : adcsq_host

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in    = 1'b0;
    logic        pdrst_n    = 1'b1;
    logic [11:0] res_bits   = 12'h000;
    logic        res_vld    = 1'b0;
    logic        cs_n, sclk, din, dout, oe_n, busy, start, abort, ready, reference_source_select, avg_en, stby, pdown;
    logic [3:0]  chan;
    logic [15:0] r;
    int          errors     = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          n_abort    = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    adcsq_top #(.TEMP_CONV_CYCLES(2000)) u_adcsq_top (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .powerdown_reset_n_in(pdrst_n), .result_bits_in(res_bits),
        .result_valid_in(res_vld), .result_ready_out(ready), .dout_out(dout), .dout_oe_n_out(oe_n),
        .temp_conversion_busy_out(busy), .conv_start_out(start), .conv_channel_out(chan), .conv_abort_out(abort),
        .reference_source_select_out(reference_source_select), .temp_average_enable_out(avg_en), .standby_out(stby),
        .powered_down_out(pdown));
    adcsq_host u_adcsq_host (.clk_sys_in(clk_sys_in), .dout_in(dout), .dout_oe_n_in(oe_n), .cs_n_out(cs_n),
        .sclk_out(sclk), .din_out(din));
    // Converter: temperature is slow so the busy window spans a frame
    always begin
        @(negedge clk_sys_in);
        if (start === 1'b1) begin
            for (int i = 0; i < (chan > 4'h7 ? 1500 : 4) && abort !== 1'b1; i++) @(negedge clk_sys_in);
            if (abort !== 1'b1) begin
                res_bits = {8'hA5, chan};
                res_vld  = 1'b1;
                while (ready !== 1'b1) @(negedge clk_sys_in);
                @(negedge clk_sys_in);
                res_vld = 1'b0;
            end
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic fr(input logic [15:0] w);
        u_adcsq_host.xfer(w, 16, r);
    endtask : fr
    task automatic t_seq();
        chk(16'({ready, oe_n, busy, stby, pdown, reference_source_select, avg_en}), 16'h0060);
        fr(16'h9404); chk(r, 16'hFFFF);
        chk(16'(reference_source_select), 16'h0001);
        fr(16'h0000); chk(r, 16'hFFFF);
        fr(16'h0000); chk(r, 16'h1A51);
        fr(16'h0000); chk(r, 16'h3A53);
        fr(16'h0000); chk(r, 16'hFFFF);
        fr(16'hC0C0); fr(16'h0000);
        fr(16'h0000); chk(r, 16'h6A56);
        fr(16'h0000); chk(r, 16'h7A57);
        fr(16'hA000); chk(r, 16'h6A56);
        fr(16'h0000); chk(r, 16'h7A57);
        fr(16'h0000); chk(r, 16'h0A50);
        fr(16'h0000); chk(r, 16'hFFFF);
        $display("sequencing done");
    endtask : t_seq
    task automatic t_temp();
        fr(16'h8002); chk(16'(avg_en), 16'h0000);
        fr(16'h8022); chk(16'(avg_en), 16'h0001);
        fr(16'h0000); chk(16'({busy, chan}), 16'h0019);
        fr(16'h8001); chk(r, 16'hFFFF);
        chk(16'(stby), 16'h0000);
        for (int i = 0; i < 2100 && busy !== 1'b0; i++) @(negedge clk_sys_in);
        chk(16'(busy), 16'h0000);
        repeat (20) @(negedge clk_sys_in);
        fr(16'h0000); chk(r, 16'h9A59);
        fr(16'h8020); chk(r, 16'hFFFF);
        fr(16'h8001); chk(16'({busy, stby, chan}), 16'h0018);
        chk(16'(n_abort), 16'h0001);
        $display("temperature done");
    endtask : t_temp
    task automatic t_mode();
        fr(16'h8023); chk(16'({stby, avg_en}), 16'h0002);
        fr(16'h0000); chk(r, 16'hFFFF);
        fr(16'h8000); chk(16'(stby), 16'h0000);
        u_adcsq_host.xfer(16'h8001, 8, r);
        chk(16'({stby, oe_n}), 16'h0001);
        chk(16'(n_abort), 16'h0002);
        fr(16'h8004);
        pdrst_n = 1'b0;
        repeat (10) @(negedge clk_sys_in);
        pdrst_n = 1'b1;
        repeat (10) @(negedge clk_sys_in);
        chk(16'({reference_source_select, pdown}), 16'h0000);
        pdrst_n = 1'b0;
        repeat (40) @(negedge clk_sys_in);
        chk(16'(pdown), 16'h0001);
        pdrst_n = 1'b1;
        repeat (10) @(negedge clk_sys_in);
        chk(16'(pdown), 16'h0000);
        $display("modes done");
    endtask : t_mode
    task automatic close_out();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    always @(negedge clk_sys_in) begin
        cycles++;
        if (abort === 1'b1) begin
            n_abort++;
        end
        if (cycles == 30000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        repeat (8) @(negedge clk_sys_in);
        t_seq();
        t_temp();
        t_mode();
        close_out();
    end
endmodule : testbench
